// File: timer_channel_map.svh
`ifndef TIMER_CHANNEL_MAP_SVH
`define TIMER_CHANNEL_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CH1_MODE_IDX 6'h07
`define CH2_MODE_IDX 6'h08
`define CH3_MODE_IDX 6'h09
`define CH_ENABLE_IDX 6'h0a
`define CH1_VALUE_IDX 6'h0b
`define CH2_VALUE_IDX 6'h0c
`define CH3_VALUE_IDX 6'h0d
`define CH_STATUS_IDX 6'h0e

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MODE_RESET 8'h00
`define ENABLE_RESET 3'h0
`define VALUE_RESET 16'h0000

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define DIR_LSB 0
`define DIR_MSB 1
`define PSC_LSB 2
`define PSC_MSB 3
`define PRELOAD_BIT 3
`define OMODE_LSB 4
`define OMODE_MSB 6
`define FILTER_LSB 4
`define FILTER_MSB 7

// ------------------------------------------------------------
// Enable register fields: channel n uses bits 2n and 2n+1
// ------------------------------------------------------------
`define EN_BIT_OF(n) (2 * (n))
`define POL_BIT_OF(n) (2 * (n) + 1)

// ------------------------------------------------------------
// Trigger selection codes that name an internal trigger
// ------------------------------------------------------------
`define TRIG_INTERNAL_A 3'h0
`define TRIG_INTERNAL_B 3'h3

`endif

// File: timer_channel_pkg.sv
package timer_channel_pkg;

	// Channel direction codes
	typedef enum logic [1:0] {
		DIR_OUTPUT = 2'h0,
		DIR_INPUT_NEAR = 2'h1,
		DIR_INPUT_FAR = 2'h2,
		DIR_INPUT_TRIG = 2'h3
	} dir_t;

	// Compare output reference modes
	typedef enum logic [2:0] {
		OM_FROZEN = 3'h0,
		OM_SET_ON_MATCH = 3'h1,
		OM_CLR_ON_MATCH = 3'h2,
		OM_TOGGLE = 3'h3,
		OM_FORCE_LOW = 3'h4,
		OM_FORCE_HIGH = 3'h5,
		OM_PWM_ONE = 3'h6,
		OM_PWM_TWO = 3'h7
	} out_mode_t;

	// Input filter state
	typedef struct packed {
		logic [4:0] rate_cnt;
		logic [3:0] agree_cnt;
		logic level;
	} filter_state_t;

	// Capture divider state
	typedef struct packed {
		logic [2:0] edge_cnt;
		logic [1:0] ratio;
		logic capture;
	} divider_state_t;

	// Main control state
	typedef struct packed {
		logic [2:0][7:0] mode;
		logic [2:0] en;
		logic [2:0] pol;
		logic [2:0][15:0] preload;
		logic [2:0][15:0] active;
		logic [2:0] ref_level;
		logic [2:0] match_q;
		logic [2:0] cmp_q;
		logic [2:0] frozen_q;
		logic [2:0] src_q;
		logic [31:0] rdata;
	} ctl_state_t;

endpackage : timer_channel_pkg

// File: input_filter.sv
`timescale 1ns/100ps
`include "timer_channel_map.svh"

module input_filter
	import timer_channel_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [3:0] filter_code_i, // Sampling rate and sample count
	input wire logic raw_i, // Synchronous channel input
	output logic filtered_o // Validated level
);

	filter_state_t st;
	filter_state_t next_st;

	// ------------------------------------------------------------
	// Code decode
	// ------------------------------------------------------------
	// Sampling divider, one less than the ratio to the master clock
	function automatic logic [4:0] rate_of(input logic [3:0] code);
		unique case (code)
			4'h0, 4'h1, 4'h2, 4'h3: rate_of = 5'h00;
			4'h4, 4'h5: rate_of = 5'h01;
			4'h6, 4'h7: rate_of = 5'h03;
			4'h8, 4'h9: rate_of = 5'h07;
			4'ha, 4'hb, 4'hc: rate_of = 5'h0f;
			default: rate_of = 5'h1f;
		endcase
	endfunction : rate_of

	// Consecutive samples needed to validate a change
	function automatic logic [3:0] count_of(input logic [3:0] code);
		unique case (code)
			4'h1: count_of = 4'h2;
			4'h2: count_of = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: count_of = 4'h6;
			4'ha, 4'hd: count_of = 4'h5;
			default: count_of = 4'h8;
		endcase
	endfunction : count_of

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (filter_code_i == 4'h0) begin
			// No filter: follow the input every clock
			next_st.level = raw_i;
			next_st.agree_cnt = 4'h0;
			next_st.rate_cnt = 5'h00;
		end else if (st.rate_cnt >= rate_of(filter_code_i)) begin
			// Sample instant; a code change mid-count just wraps here
			next_st.rate_cnt = 5'h00;
			if (raw_i == st.level) begin
				next_st.agree_cnt = 4'h0;
			end else if (st.agree_cnt + 4'h1 >= count_of(filter_code_i)) begin
				next_st.level = raw_i;
				next_st.agree_cnt = 4'h0;
			end else begin
				next_st.agree_cnt = st.agree_cnt + 4'h1;
			end
		end else begin
			next_st.rate_cnt = st.rate_cnt + 5'h01;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	assign filtered_o = st.level;

endmodule : input_filter

// File: capture_divider.sv
`timescale 1ns/100ps
`include "timer_channel_map.svh"

module capture_divider
	import timer_channel_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic enable_i, // Capture permitted
	input wire logic [1:0] ratio_i, // Programmed divider code
	input wire logic edge_i, // Valid edge pulse
	output logic capture_o // One-cycle capture pulse
);

	divider_state_t st;
	divider_state_t next_st;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.capture = 1'b0;
		if (!enable_i) begin
			// Disabled: count cleared and new ratio picked up at once
			next_st.edge_cnt = 3'h0;
			next_st.ratio = ratio_i;
		end else if (edge_i) begin
			if (st.edge_cnt == 3'((4'h1 << st.ratio) - 4'h1)) begin
				next_st.capture = 1'b1;
				next_st.edge_cnt = 3'h0;
				// While enabled, ratio changes land only after a capture
				next_st.ratio = ratio_i;
			end else begin
				next_st.edge_cnt = st.edge_cnt + 3'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	assign capture_o = st.capture;

endmodule : capture_divider

// File: timer_channel_mode_control.sv
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "timer_channel_map.svh"

module timer_channel_mode_control
	import timer_channel_pkg::*;
#(
	parameter int CHANNELS = 3, // Channel count served by this block
	parameter int COUNT_WIDTH = 16 // Counter and compare width
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Time base
	input wire logic [15:0] counter_value_i,
	input wire logic count_down_i,
	input wire logic update_event_i,
	input wire logic [2:0] trigger_select_field_i,
	input wire logic slave_trigger_source_i,
	// Channel pins
	input wire logic [2:0] ch_pin_i,
	output logic [2:0] ch_pin_o,
	output logic [2:0] ch_pin_oe_n_o,
	// Status toward the rest of the timer
	output logic [2:0] ch_output_reference_o,
	output logic [2:0] capture_event_o,
	output logic [2:0] compare_match_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The register map and pin fan-out are built for exactly three
	// channels on a sixteen-bit counter.
	if (CHANNELS != 3) begin : g_bad_channels
		$error("timer_channel_mode_control serves three channels only");
	end
	if (COUNT_WIDTH != 16) begin : g_bad_width
		$error("timer_channel_mode_control needs a 16-bit counter");
	end

	// ------------------------------------------------------------
	// State and wiring
	// ------------------------------------------------------------
	ctl_state_t st; // All registered state
	ctl_state_t next_st; // Its next value
	logic [2:0] filtered; // Filtered pin levels, one per input
	logic [2:0] src; // Capture source chosen per channel
	logic [2:0] valid_edge; // Edge of the chosen polarity
	logic [2:0] capture; // Divided capture pulses
	logic [2:0] cmp; // Comparison result per channel
	logic [2:0] match; // Counter equals active compare
	logic [2:0] cap_enable; // Capture permitted per channel
	logic trig_internal; // Trigger selection names an internal source
	logic setup; // APB setup phase
	logic access; // APB access phase
	logic wr_en; // Write takes effect this edge
	logic [5:0] idx; // Register index from the address
	logic mapped; // Index hits a register

	// Channel is in input direction
	function automatic logic is_input(input logic [7:0] mode);
		is_input = dir_t'(mode[`DIR_MSB:`DIR_LSB]) != DIR_OUTPUT;
	endfunction : is_input

	// Register index is one of the mapped registers
	function automatic logic index_mapped(input logic [5:0] i);
		index_mapped = (i >= `CH1_MODE_IDX) && (i <= `CH_STATUS_IDX);
	endfunction : index_mapped

	// ------------------------------------------------------------
	// Input filters, one per physical input
	// ------------------------------------------------------------
	// Input n is filtered with the filter field of mode register n.
	for (genvar n = 0; n < 3; n++) begin : g_filter
		input_filter input_filter_inst (
			.clk_sys_i(clk_sys_i),
			.sys_rst_i(sys_rst_i),
			.clk_en_i(clk_en_i),
			.filter_code_i(st.mode[n][`FILTER_MSB:`FILTER_LSB]),
			.raw_i(ch_pin_i[n]),
			.filtered_o(filtered[n])
		);
	end

	// ------------------------------------------------------------
	// Capture source selection and edge detection
	// ------------------------------------------------------------
	assign trig_internal = (trigger_select_field_i == `TRIG_INTERNAL_A) ||
		(trigger_select_field_i == `TRIG_INTERNAL_B);

	always_comb begin
		// Channel 1: near input 1, far input 2, or trigger
		unique case (dir_t'(st.mode[0][`DIR_MSB:`DIR_LSB]))
			DIR_INPUT_NEAR: src[0] = filtered[0];
			DIR_INPUT_FAR: src[0] = filtered[1];
			DIR_INPUT_TRIG: src[0] = slave_trigger_source_i & trig_internal;
			default: src[0] = 1'b0;
		endcase
		// Channel 2: codes mirror channel 1 with inputs swapped
		unique case (dir_t'(st.mode[1][`DIR_MSB:`DIR_LSB]))
			DIR_INPUT_NEAR: src[1] = filtered[1];
			DIR_INPUT_FAR: src[1] = filtered[0];
			DIR_INPUT_TRIG: src[1] = slave_trigger_source_i & trig_internal;
			default: src[1] = 1'b0;
		endcase
		// Channel 3: only its own input
		src[2] = (st.mode[2][`DIR_MSB:`DIR_LSB] == DIR_INPUT_NEAR) & filtered[2];
	end

	// Edge sense set by polarity; a direction change may give one stray edge
	always_comb begin
		for (int n = 0; n < 3; n++) begin
			valid_edge[n] = st.pol[n] ? (st.src_q[n] & ~src[n]) :
				(~st.src_q[n] & src[n]);
			cap_enable[n] = st.en[n] & is_input(st.mode[n]);
		end
	end

	// ------------------------------------------------------------
	// Capture dividers
	// ------------------------------------------------------------
	for (genvar n = 0; n < 3; n++) begin : g_divider
		capture_divider capture_divider_inst (
			.clk_sys_i(clk_sys_i),
			.sys_rst_i(sys_rst_i),
			.clk_en_i(clk_en_i),
			.enable_i(cap_enable[n]),
			.ratio_i(st.mode[n][`PSC_MSB:`PSC_LSB]),
			.edge_i(valid_edge[n]),
			.capture_o(capture[n])
		);
	end

	// ------------------------------------------------------------
	// Comparison
	// ------------------------------------------------------------
	always_comb begin
		for (int n = 0; n < 3; n++) begin
			match[n] = counter_value_i == st.active[n];
			// Reference for PWM one; PWM two uses its inverse
			if (count_down_i) begin
				cmp[n] = !(counter_value_i > st.active[n]);
			end else begin
				cmp[n] = counter_value_i < st.active[n];
			end
		end
	end

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Zero wait states: read data is registered in the setup phase
	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i;
	assign idx = paddr_i[7:2];
	assign mapped = index_mapped(idx) && (paddr_i[1:0] == 2'h0);
	assign wr_en = access & pwrite_i & mapped & pstrb_i[0];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [2:0] om;
		logic [15:0] wval;
		om = 3'h0;
		wval = 16'h0000;
		next_st = st;
		next_st.src_q = src;
		next_st.match_q = match;
		next_st.cmp_q = cmp;

		for (int n = 0; n < 3; n++) begin
			om = st.mode[n][`OMODE_MSB:`OMODE_LSB];
			next_st.frozen_q[n] = out_mode_t'(om) == OM_FROZEN;

			// Output reference; the match modes act on the first cycle of a match
			unique case (out_mode_t'(om))
				OM_FROZEN: begin
					next_st.ref_level[n] = st.ref_level[n];
				end
				OM_SET_ON_MATCH: begin
					if (match[n] & ~st.match_q[n]) begin
						next_st.ref_level[n] = 1'b1;
					end
				end
				OM_CLR_ON_MATCH: begin
					if (match[n] & ~st.match_q[n]) begin
						next_st.ref_level[n] = 1'b0;
					end
				end
				OM_TOGGLE: begin
					if (match[n] & ~st.match_q[n]) begin
						next_st.ref_level[n] = ~st.ref_level[n];
					end
				end
				OM_FORCE_LOW: begin
					next_st.ref_level[n] = 1'b0;
				end
				OM_FORCE_HIGH: begin
					next_st.ref_level[n] = 1'b1;
				end
				OM_PWM_ONE, OM_PWM_TWO: begin
					// Follow only a changed result or a start from frozen
					if ((cmp[n] != st.cmp_q[n]) || st.frozen_q[n]) begin
						next_st.ref_level[n] = (out_mode_t'(om) == OM_PWM_ONE) ?
							cmp[n] : ~cmp[n];
					end
				end
			endcase

			// Preload transfer at update; only for output channels with preload enabled
			if (!is_input(st.mode[n]) && st.mode[n][`PRELOAD_BIT] && update_event_i) begin
				next_st.active[n] = st.preload[n];
			end

			// Captured counter value lands in the active register
			if (capture[n]) begin
				next_st.active[n] = counter_value_i;
			end
		end

		// Register writes; with preload on, an update in the same edge moves the old preload to active and the write stays in preload
		if (wr_en) begin
			wval = pwdata_i[15:0];
			unique case (idx)
				`CH1_MODE_IDX, `CH2_MODE_IDX, `CH3_MODE_IDX: begin
					for (int n = 0; n < 3; n++) begin
						if (idx == 6'(`CH1_MODE_IDX + n)) begin
							// Upper fields always writable
							next_st.mode[n][7:2] = pwdata_i[7:2];
							// Direction only while the channel is off
							if (!st.en[n] && !(n == 2 && pwdata_i[1])) begin
								next_st.mode[n][1:0] = pwdata_i[1:0];
							end
						end
					end
				end
				`CH_ENABLE_IDX: begin
					for (int n = 0; n < 3; n++) begin
						next_st.en[n] = pwdata_i[`EN_BIT_OF(n)];
						next_st.pol[n] = pwdata_i[`POL_BIT_OF(n)];
					end
				end
				`CH1_VALUE_IDX, `CH2_VALUE_IDX, `CH3_VALUE_IDX: begin
					for (int n = 0; n < 3; n++) begin
						// Captured values are read-only for input channels
						if (idx == 6'(`CH1_VALUE_IDX + n) && !is_input(st.mode[n])) begin
							if (st.mode[n][`PRELOAD_BIT]) begin
								next_st.preload[n] = wval;
							end else begin
								next_st.preload[n] = wval;
								next_st.active[n] = wval;
							end
						end
					end
				end
				default: begin
					// Status register is read-only
				end
			endcase
		end

		// Read data captured in the setup phase, zero when the index hits no register
		if (setup) begin
			next_st.rdata = 32'h0000_0000;
			unique case (idx)
				`CH1_MODE_IDX: next_st.rdata[7:0] = st.mode[0];
				`CH2_MODE_IDX: next_st.rdata[7:0] = st.mode[1];
				`CH3_MODE_IDX: next_st.rdata[7:0] = st.mode[2];
				`CH_ENABLE_IDX: begin
					for (int n = 0; n < 3; n++) begin
						next_st.rdata[`EN_BIT_OF(n)] = st.en[n];
						next_st.rdata[`POL_BIT_OF(n)] = st.pol[n];
					end
				end
				`CH1_VALUE_IDX, `CH2_VALUE_IDX, `CH3_VALUE_IDX: begin
					for (int n = 0; n < 3; n++) begin
						if (idx == 6'(`CH1_VALUE_IDX + n)) begin
							next_st.rdata[15:0] = (!is_input(st.mode[n]) &&
								st.mode[n][`PRELOAD_BIT]) ? st.preload[n] : st.active[n];
						end
					end
				end
				`CH_STATUS_IDX: begin
					// Live view of references and filtered inputs
					next_st.rdata[2:0] = st.ref_level;
					next_st.rdata[6:4] = filtered;
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Clock enable low freezes everything, bus included
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata_o = st.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = access & ~mapped;
	assign ch_output_reference_o = st.ref_level;
	assign capture_event_o = capture;
	assign compare_match_o = st.match_q;

	// Pin driven only for an enabled output channel
	always_comb begin
		for (int n = 0; n < 3; n++) begin
			ch_pin_o[n] = st.ref_level[n] ^ st.pol[n];
			ch_pin_oe_n_o[n] = is_input(st.mode[n]) | ~st.en[n];
		end
	end

endmodule : timer_channel_mode_control

// File: timer_channel_mode_control_props.sv
`timescale 1ns/100ps
module mode_control_props (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [2:0] ch_pin_o,
	input wire logic [2:0] ch_output_reference_o,
	input wire logic [2:0] capture_event_o,
	input wire logic [2:0] compare_match_o
);
	// ------
	// Shadow fields
	// ------
	logic [2:0] om; // Channel 1 output mode
	logic pol; // Channel 1 polarity
	logic en2; // Channel 2 enable
	logic wr; // Write accepted at this edge
	assign wr = psel_i & penable_i & pwrite_i & pstrb_i[0] & clk_en_i;
	// Loaded on the same edge as the block's mode; the reference still lags it by one edge
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			om <= 3'h0;
			pol <= 1'b0;
			en2 <= 1'b0;
		end else if (wr && paddr_i == 8'h1c) begin
			om <= pwdata_i[6:4];
		end else if (wr && paddr_i == 8'h28) begin
			pol <= pwdata_i[1];
			en2 <= pwdata_i[2];
		end
	end
	// ------
	// Properties
	// ------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	property p_frozen;
		om == 3'h0 && $past(om) == 3'h0 |-> $stable(ch_output_reference_o[0]);
	endproperty
	a_frozen: assert property (p_frozen) else $error("reference moved while frozen");
	property p_set;
		$rose(compare_match_o[0]) && om == 3'h1 |-> ch_output_reference_o[0];
	endproperty
	a_set: assert property (p_set) else $error("match did not set reference");
	property p_clr;
		$rose(compare_match_o[0]) && om == 3'h2 |-> !ch_output_reference_o[0];
	endproperty
	a_clr: assert property (p_clr) else $error("match did not clear reference");
	property p_toggle;
		$rose(compare_match_o[0]) && om == 3'h3
			|-> ch_output_reference_o[0] != $past(ch_output_reference_o[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("match did not invert reference");
	property p_force_low;
		(om == 3'h4) [*2] |=> !ch_output_reference_o[0];
	endproperty
	a_force_low: assert property (p_force_low) else $error("forced low not held");
	property p_force_high;
		om == 3'h5 && $past(om) == 3'h5 |-> ch_output_reference_o[0];
	endproperty
	a_force_high: assert property (p_force_high) else $error("forced high not held");
	property p_polarity;
		ch_pin_o[0] == (ch_output_reference_o[0] ^ pol);
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin level not reference xor polarity");
	property p_capture_gate;
		(!en2) [*3] |-> !capture_event_o[1];
	endproperty
	a_capture_gate: assert property (p_capture_gate) else $error("capture while disabled");
endmodule : mode_control_props

bind timer_channel_mode_control mode_control_props props_inst (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pstrb_i(pstrb_i), .ch_pin_o(ch_pin_o), .ch_output_reference_o(ch_output_reference_o),
	.capture_event_o(capture_event_o), .compare_match_o(compare_match_o)
);

// File: pin_source.sv
`timescale 1ns/100ps
module pin_source (
	input wire logic clk_sys_i,
	input wire logic [2:0] level_i, // Level applied from outside
	input wire logic trig_i, // Requested trigger level
	input wire logic [2:0] ch_pin_o, // Level the block drives
	input wire logic [2:0] ch_pin_oe_n_o, // Low where the block drives
	output logic [2:0] pins_o, // Resolved pin level
	output logic trig_o // Trigger source toward the block
);
	logic [2:0] ext = 3'h0; // Outside level, moves only after an edge
	logic trig_q = 1'b0; // Trigger level, same timing
	always_ff @(posedge clk_sys_i) begin
		ext <= level_i;
		trig_q <= trig_i;
	end
	assign trig_o = trig_q;
	// The block wins where it drives; elsewhere the outside level shows
	assign pins_o = (ch_pin_o & ~ch_pin_oe_n_o) | (ext & ch_pin_oe_n_o);
endmodule : pin_source

// File: timer_channel_mode_control_bench.sv
`timescale 1ns/100ps
module timer_channel_mode_control_bench;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, down = 1'b0, upd = 1'b0, trig = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, trig_in;
	logic [15:0] cnt = 16'h0;
	logic [2:0] ts = 3'h0, level = 3'h0, pin_in, pin_d, oe_n, ref_o, cap, match;
	int errors = 0, compares = 0, c1 = 0, c2 = 0;
	// Clock and capture tallies
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		c1 <= c1 + int'(cap[0] === 1'b1);
		c2 <= c2 + int'(cap[1] === 1'b1);
	end
	timer_channel_mode_control timer_channel_mode_control_inst (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.counter_value_i(cnt), .count_down_i(down), .update_event_i(upd),
		.trigger_select_field_i(ts), .slave_trigger_source_i(trig_in), .ch_pin_i(pin_in),
		.ch_pin_o(pin_d), .ch_pin_oe_n_o(oe_n), .ch_output_reference_o(ref_o),
		.capture_event_o(cap), .compare_match_o(match));
	pin_source pin_source_inst (.clk_sys_i(clk_sys_i), .level_i(level), .trig_i(trig),
		.ch_pin_o(pin_d), .ch_pin_oe_n_o(oe_n), .pins_o(pin_in), .trig_o(trig_in));
	task automatic report_and_stop();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// One transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk_sys_i);
			if (pready === 1'b1)
				break;
		end
		if (n == 16) begin
			errors++;
			report_and_stop();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x,
			input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, q, x);
		check({nm, " err"}, e, xe);
	endtask : rd_chk
	// Settle n edges, then look between edges
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : idle
	task automatic hit(input logic [15:0] v);
		@(posedge clk_sys_i);
		cnt <= v;
		repeat (3) @(posedge clk_sys_i);
		cnt <= 16'h0;
		idle(3);
	endtask : hit
	task automatic pulse(input int hi, input int lo);
		@(posedge clk_sys_i);
		level[1] <= 1'b1;
		repeat (hi) @(posedge clk_sys_i);
		level[1] <= 1'b0;
		repeat (lo) @(posedge clk_sys_i);
	endtask : pulse
	task automatic s_reset();
		rd_chk("mode1", 8'h1c, 32'h0, 1'b0);
		rd_chk("mode2", 8'h20, 32'h0, 1'b0);
		rd_chk("mode3", 8'h24, 32'h0, 1'b0);
		rd_chk("unmapped", 8'h3c, 32'h0, 1'b1);
	endtask : s_reset
	task automatic s_output();
		logic [2:0] m [8] = '{1, 2, 3, 3, 5, 0, 4, 0};
		logic x [8] = '{1, 0, 1, 0, 1, 1, 0, 0};
		wr(8'h28, 32'h1);
		wr(8'h2c, 32'h10);
		foreach (m[i]) begin
			wr(8'h1c, {25'h0, m[i], 4'h0});
			hit(16'h10);
			check("ref", ref_o[0], x[i]);
		end
		wr(8'h28, 32'h3);
		idle(2);
		check("pin", pin_d[0], 1'b1);
		check("oe_n", oe_n[0], 1'b0);
		wr(8'h1c, 32'h1);
		rd_chk("dir locked", 8'h1c, 32'h0, 1'b0);
		wr(8'h24, 32'h3);
		rd_chk("ch3 dir", 8'h24, 32'h0, 1'b0);
		wr(8'h24, 32'h1);
		rd_chk("ch3 in", 8'h24, 32'h1, 1'b0);
	endtask : s_output
	task automatic s_pwm();
		logic [16:0] v [5] = '{17'h00005, 17'h00020, 17'h10020, 17'h10010, 17'h10008};
		logic x [5] = '{1, 0, 0, 1, 1};
		wr(8'h1c, 32'h68);
		foreach (v[i]) begin
			@(posedge clk_sys_i);
			{down, cnt} <= v[i];
			idle(3);
			check("pwm1", ref_o[0], x[i]);
		end
		wr(8'h1c, 32'h0);
		wr(8'h1c, 32'h78);
		idle(2);
		check("pwm2", ref_o[0], 1'b0);
		wr(8'h1c, 32'h0);
		wr(8'h1c, 32'h68);
		@(posedge clk_sys_i);
		{down, cnt} <= 17'h00018;
		wr(8'h2c, 32'h20);
		idle(2);
		check("preload", ref_o[0], 1'b0);
		rd_chk("preload rd", 8'h2c, 32'h20, 1'b0);
		@(posedge clk_sys_i);
		upd <= 1'b1;
		@(posedge clk_sys_i);
		upd <= 1'b0;
		idle(3);
		check("update", ref_o[0], 1'b1);
	endtask : s_pwm
	task automatic s_capture();
		int s;
		wr(8'h20, 32'h01);
		wr(8'h28, 32'h4);
		@(posedge clk_sys_i);
		cnt <= 16'h55;
		pulse(2, 6);
		rd_chk("captured", 8'h30, 32'h55, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h28, 32'h0);
			wr(8'h20, 32'h1 | (c << 2));
			wr(8'h28, 32'h4);
			s = c2;
			repeat (8) pulse(2, 4);
			check("divider", c2 - s, 8 >> c);
		end
		wr(8'h28, 32'h0);
		s = c2;
		repeat (2) pulse(2, 4);
		check("disabled", c2 - s, 0);
		wr(8'h20, 32'h31);
		wr(8'h28, 32'h4);
		s = c2;
		pulse(5, 1);
		pulse(5, 20);
		check("glitch", c2 - s, 0);
		pulse(12, 20);
		check("filtered", c2 - s, 1);
	endtask : s_capture
	task automatic s_trigger();
		logic [2:0] t [4] = '{3'h0, 3'h3, 3'h1, 3'h7};
		int x [4] = '{1, 1, 0, 0};
		int s;
		wr(8'h28, 32'h0);
		wr(8'h1c, 32'h3);
		wr(8'h28, 32'h1);
		foreach (t[i]) begin
			@(posedge clk_sys_i);
			ts <= t[i];
			trig <= 1'b1;
			s = c1;
			repeat (4) @(posedge clk_sys_i);
			trig <= 1'b0;
			idle(4);
			check("trigger", c1 - s, x[i]);
		end
		wr(8'h28, 32'h0);
		wr(8'h1c, 32'h2);
		wr(8'h28, 32'h3);
		s = c1;
		pulse(10, 12);
		check("far fall", c1 - s, 1);
		check("oe_n in", oe_n[0], 1'b1);
	endtask : s_trigger
	initial begin
		repeat (3) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		s_reset();
		s_output();
		s_pwm();
		s_capture();
		s_trigger();
		report_and_stop();
	end
endmodule : timer_channel_mode_control_bench
